// ### dmb_consts.svh
// Constants of the multiply-accumulate block: widths, offsets, fields.
// Assumes inclusion by bare name from every file that needs them.
`ifndef DMB_CONSTS_SVH
`define DMB_CONSTS_SVH
`define DMB_OPW 18
`define DMB_PRW 36
`define DMB_ACCW 52
`define DMB_SUMW 53
`define DMB_CTLW 10
`define DMB_ADR_CTRL 8'h00
`define DMB_ADR_STAT 8'h04
`define DMB_ADR_RLO 8'h08
`define DMB_ADR_RHI 8'h0c
`define DMB_ADR_CAP0 8'h10
`define DMB_ADR_CAP1 8'h14
`define DMB_C_MODE 0
`define DMB_C_INEN 1
`define DMB_C_PPEN 2
`define DMB_C_OTEN 3
`define DMB_C_SDYN 4
`define DMB_C_SSTA 5
`define DMB_C_ADYN 6
`define DMB_C_ASTA 7
`define DMB_C_SHA 8
`define DMB_C_SHB 9
`define DMB_C_CLR 10
`define DMB_CTRL_RST 10'h00e
`define DMB_CAP0_VAL 32'h22422148
`define DMB_CAP1_VAL 32'h00000001
`endif

// ### dmb_pkg.sv
// Types shared by the multiply-accumulate block.
// Assumes the constants header is on the include path.
`include "dmb_consts.svh"
package dmb_pkg;
  typedef enum logic [0:0] {
    DMB_MODE_MULTIPLY_ONLY_ELEMENT = 1'b0,
    DMB_MODE_MAC = 1'b1
  } dmb_mode_t;
  typedef logic [`DMB_OPW-1:0] dmb_opnd_t;
endpackage

// ### dmb_opnd_if.sv
// Signals of one operand register stage.
// Assumes the package is compiled first.
`timescale 1ns/1ps
interface dmb_opnd_if;
  dmb_pkg::dmb_opnd_t d;
  dmb_pkg::dmb_opnd_t sri;
  dmb_pkg::dmb_opnd_t q;
  dmb_pkg::dmb_opnd_t op;
  logic load_en;
  logic shift_sel;
  logic byp;
  modport stage (input d, sri, load_en, shift_sel, byp, output q, op);
  modport user (output d, sri, load_en, shift_sel, byp, input q, op);
endinterface

// ### dmb_opnd_reg.sv
// Operand register with shift-chain load and bypass.
// Assumes a synchronous active-high reset on the shared clock.
`timescale 1ns/1ps
module dmb_opnd_reg (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Stage signals
  dmb_opnd_if.stage s
);
  // Direct or chained load
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s.q <= '0;
    end else if (s.load_en) begin
      s.q <= s.shift_sel ? s.sri : s.d;
    end
  end

  assign s.op = s.byp ? s.d : s.q;
endmodule

// ### dmb_top.sv
// Multiply and multiply-accumulate element with Wishbone control.
// Assumes fabric inputs synchronous to clk_i; classic Wishbone master.
//
// The Wishbone slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "dmb_consts.svh"
module dmb_top (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Fabric operands and controls
  input wire logic [`DMB_OPW-1:0] a_i,
  input wire logic [`DMB_OPW-1:0] b_i,
  input wire logic [`DMB_OPW-1:0] a_sri_i,
  input wire logic [`DMB_OPW-1:0] b_sri_i,
  input wire logic signed_i,
  input wire logic addsub_i,
  input wire logic ce_i,
  // Results
  output logic [`DMB_ACCW-1:0] result_o,
  output logic ovf_o,
  output logic [`DMB_OPW-1:0] a_sro_o,
  output logic [`DMB_OPW-1:0] b_sro_o
);
  logic [`DMB_CTLW-1:0] ctrl;
  dmb_pkg::dmb_mode_t mode;
  logic mode_mac;
  logic in_en;
  logic pipe_en;
  logic out_en;
  logic wb_hit;
  logic wr_go;
  logic clr;
  logic [31:0] rd_mux;
  logic sgn_in;
  logic sub_in;
  logic s1_sgn;
  logic s1_sub;
  logic sgn1;
  logic sub1;
  logic signed [`DMB_OPW:0] ax;
  logic signed [`DMB_OPW:0] bx;
  logic signed [2*`DMB_OPW+1:0] prod_full;
  logic [`DMB_PRW-1:0] prod;
  logic [`DMB_PRW-1:0] p2_prod;
  logic p2_sgn;
  logic p2_sub;
  logic [`DMB_PRW-1:0] prod2;
  logic sgn2;
  logic sub2;
  logic [`DMB_SUMW-1:0] pext;
  logic [`DMB_SUMW-1:0] aext;
  logic [`DMB_SUMW-1:0] sum;
  logic ovf_now;
  logic acc_upd;
  logic [`DMB_ACCW-1:0] acc;
  logic ovf;
  logic [`DMB_ACCW-1:0] mext;
  logic [`DMB_ACCW-1:0] m3;
  logic [`DMB_ACCW-1:0] mout;

  dmb_opnd_if ia ();
  dmb_opnd_if ib ();

  // Configuration fields
  assign mode = dmb_pkg::dmb_mode_t'(ctrl[`DMB_C_MODE]);
  assign mode_mac = (mode == dmb_pkg::DMB_MODE_MAC);
  assign in_en = ctrl[`DMB_C_INEN];
  assign pipe_en = ctrl[`DMB_C_PPEN];
  assign out_en = ctrl[`DMB_C_OTEN];

  // Wishbone handshake
  assign wb_hit = wb_cyc_i & wb_stb_i;
  assign wr_go = wb_hit & wb_we_i & wb_ack_o;
  assign clr = wr_go & wb_sel_i[1] & (wb_adr_i == `DMB_ADR_CTRL) &
               wb_dat_i[`DMB_C_CLR];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_hit & ~wb_ack_o;
    end
  end

  // Read data
  always_comb begin
    case (wb_adr_i)
      `DMB_ADR_CTRL: rd_mux = {22'h000000, ctrl};
      `DMB_ADR_STAT: rd_mux = {30'h00000000, mode_mac, ovf_o};
      `DMB_ADR_RLO: rd_mux = result_o[31:0];
      `DMB_ADR_RHI: rd_mux = {12'h000, result_o[`DMB_ACCW-1:32]};
      `DMB_ADR_CAP0: rd_mux = `DMB_CAP0_VAL;
      `DMB_ADR_CAP1: rd_mux = `DMB_CAP1_VAL;
      default: rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h00000000;
    end else if (wb_hit & ~wb_ack_o) begin
      wb_dat_o <= rd_mux;
    end
  end

  // Control register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= `DMB_CTRL_RST;
    end else if (wr_go && wb_adr_i == `DMB_ADR_CTRL) begin
      if (wb_sel_i[0]) begin
        ctrl[7:0] <= wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        ctrl[9:8] <= wb_dat_i[9:8];
      end
    end
  end

  // Operand stages
  assign ia.d = a_i;
  assign ia.sri = a_sri_i;
  assign ia.load_en = ce_i;
  assign ia.shift_sel = ctrl[`DMB_C_SHA];
  assign ia.byp = ~in_en;
  assign ib.d = b_i;
  assign ib.sri = b_sri_i;
  assign ib.load_en = ce_i;
  assign ib.shift_sel = ctrl[`DMB_C_SHB];
  assign ib.byp = ~in_en;

  dmb_opnd_reg u_opa (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .s(ia.stage)
  );

  dmb_opnd_reg u_opb (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .s(ib.stage)
  );

  assign a_sro_o = ia.q;
  assign b_sro_o = ib.q;

  // Per-cycle sign and direction
  assign sgn_in = ctrl[`DMB_C_SDYN] ? signed_i : ctrl[`DMB_C_SSTA];
  assign sub_in = ctrl[`DMB_C_ADYN] ? addsub_i : ctrl[`DMB_C_ASTA];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_sgn <= 1'b0;
      s1_sub <= 1'b0;
    end else if (ce_i) begin
      s1_sgn <= sgn_in;
      s1_sub <= sub_in;
    end
  end

  assign sgn1 = in_en ? s1_sgn : sgn_in;
  assign sub1 = in_en ? s1_sub : sub_in;

  // Multiplier
  assign ax = {sgn1 & ia.op[`DMB_OPW-1], ia.op};
  assign bx = {sgn1 & ib.op[`DMB_OPW-1], ib.op};
  assign prod_full = ax * bx;
  assign prod = prod_full[`DMB_PRW-1:0];

  // Pipeline register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      p2_prod <= '0;
      p2_sgn <= 1'b0;
      p2_sub <= 1'b0;
    end else if (ce_i) begin
      p2_prod <= prod;
      p2_sgn <= sgn1;
      p2_sub <= sub1;
    end
  end

  assign prod2 = pipe_en ? p2_prod : prod;
  assign sgn2 = pipe_en ? p2_sgn : sgn1;
  assign sub2 = pipe_en ? p2_sub : sub1;

  // Accumulator adder and range check
  assign pext = {{(`DMB_SUMW-`DMB_PRW){sgn2 & prod2[`DMB_PRW-1]}}, prod2};
  assign aext = {sgn2 & acc[`DMB_ACCW-1], acc};
  assign sum = sub2 ? aext - pext : aext + pext;
  assign ovf_now = sgn2 ? (sum[`DMB_SUMW-1] ^ sum[`DMB_ACCW-1]) :
                   sum[`DMB_SUMW-1];
  assign acc_upd = mode_mac & ce_i & ~clr;

  always_ff @(posedge clk_i) begin
    if (rst_i || clr) begin
      acc <= '0;
    end else if (acc_upd) begin
      acc <= sum[`DMB_ACCW-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || clr) begin
      ovf <= 1'b0;
    end else if (acc_upd) begin
      ovf <= ovf_now;
    end
  end

  // Multiply-only output register
  assign mext = {{(`DMB_ACCW-`DMB_PRW){sgn2 & prod2[`DMB_PRW-1]}}, prod2};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      m3 <= '0;
    end else if (ce_i && !mode_mac) begin
      m3 <= mext;
    end
  end

  assign mout = out_en ? m3 : mext;

  // Result and flag outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      result_o <= '0;
    end else if (ce_i) begin
      result_o <= mode_mac ? acc : mout;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ovf_o <= 1'b0;
    end else begin
      ovf_o <= ovf;
    end
  end

  // Checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  cap_read_a: assert property (
    wb_ack_o && !wb_we_i && wb_adr_i == `DMB_ADR_CAP0 && $past(wb_hit)
    |-> wb_dat_o == `DMB_CAP0_VAL)
    else $error("capability word wrong");

  shift_load_a: assert property (
    ce_i && ctrl[`DMB_C_SHA] |=> a_sro_o == $past(a_sri_i))
    else $error("chained operand load failed");

  sign_dyn_a: assert property (
    ce_i && ctrl[`DMB_C_SDYN] && !wr_go |=> s1_sgn == $past(signed_i))
    else $error("dynamic sign not taken");

  sub_dyn_a: assert property (
    ce_i && ctrl[`DMB_C_ADYN] && !wr_go |=> s1_sub == $past(addsub_i))
    else $error("dynamic add/sub not taken");

  multiply_only_element_noacc_a: assert property (
    !mode_mac && !clr |=> $stable(acc))
    else $error("accumulator moved in multiply-only mode");

  multiply_only_element_inreg_a: assert property (
    ce_i && !ctrl[`DMB_C_SHA] |=> ia.q == $past(a_i))
    else $error("input register did not load operand");

  mac_add_a: assert property (
    acc_upd && !sub2
    |=> acc == $past(acc) + $past(pext[`DMB_ACCW-1:0]))
    else $error("accumulate sum wrong");

  mac_out_a: assert property (
    mode_mac && ce_i |=> result_o == $past(acc))
    else $error("result does not show accumulator");

  ovf_reg_a: assert property (
    $changed(ovf) |-> $past(acc_upd) || $past(clr) || $past(rst_i))
    else $error("overflow changed without update");

  ovf_uns_a: assert property (
    acc_upd && !sgn2 && sum[`DMB_SUMW-1] |=> ovf ##1 ovf_o)
    else $error("unsigned overflow missed");

  ce_hold_a: assert property (
    !ce_i && !clr |=> $stable(acc) && $stable(result_o))
    else $error("state moved with enable low");

  mac_ovf_c: cover property (acc_upd ##1 ovf);
  mac_sub_c: cover property (acc_upd && sub2 && sgn2);
  shift_c: cover property (ce_i && ctrl[`DMB_C_SHA] && in_en);
  wb_write_c: cover property (wr_go && wb_adr_i == `DMB_ADR_CTRL);
endmodule

// ### dmb_fabric_model.sv
// Fabric user logic feeding operands and per-cycle controls.
// Assumes the bench sets new values just after a rising clock edge.
`timescale 1ns/1ps
`include "dmb_consts.svh"
module dmb_fabric_model (
  // From the bench
  input wire logic [`DMB_OPW-1:0] a_i,
  input wire logic [`DMB_OPW-1:0] b_i,
  input wire logic sgn_i,
  input wire logic sub_i,
  // Towards the block
  output logic [`DMB_OPW-1:0] a_o,
  output logic [`DMB_OPW-1:0] b_o,
  output logic sgn_o,
  output logic sub_o
);
  assign a_o = a_i;
  assign b_o = b_i;
  assign sgn_o = sgn_i;
  assign sub_o = sub_i;
endmodule

// ### dsp_multiply_accumulate_block_tb_top.sv
// Self-checking bench of the multiply-accumulate block.
// Assumes design files and fabric model are compiled first.
`timescale 1ns/1ps
`include "dmb_consts.svh"
module dsp_multiply_accumulate_block_tb_top;
  logic clk_i = 0;
  logic rst_i = 1;
  logic cyc = 0, stb = 0, we = 0, ack, ce = 1, ovf;
  logic sgn = 0, sub = 0, sg, sb;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, rd, dat_o;
  logic [`DMB_OPW-1:0] an = 0, bn = 0, asr = 0, bsr = 0, a, b, asro, bsro;
  logic [`DMB_ACCW-1:0] res;
  int fails = 0, compares = 0, cycles = 0;

  dmb_fabric_model fab_u (.a_i(an), .b_i(bn), .sgn_i(sgn), .sub_i(sub),
    .a_o(a), .b_o(b), .sgn_o(sg), .sub_o(sb));
  dmb_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
    .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack), .a_i(a), .b_i(b),
    .a_sri_i(asr), .b_sri_i(bsr), .signed_i(sg), .addsub_i(sb),
    .ce_i(ce), .result_o(res), .ovf_o(ovf), .a_sro_o(asro),
    .b_sro_o(bsro));

  initial forever #12.5 clk_i = ~clk_i;

  task summarize;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 4000) begin
      fails++;
      summarize;
    end
  end

  task chk(input string nm, input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Classic single Wishbone cycle, read data left in rd
  task wbx(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= ad;
    wdat <= d;
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    rd = dat_o;
    cyc <= 0;
    stb <= 0;
  endtask

  // Multiply-only with a given register selection and latency
  task multiply_only_element_t(input logic [31:0] ctl, input int lat, input logic [51:0] exp);
    wbx(1, `DMB_ADR_CTRL, ctl);
    an <= 0;
    bn <= 0;
    asr <= 0;
    bsr <= 0;
    repeat (6) @(posedge clk_i);
    an <= 7;
    bn <= 9;
    asr <= 11;
    bsr <= 3;
    repeat (lat - 1) @(posedge clk_i);
    @(negedge clk_i);
    chk("mul early", res, 0);
    @(posedge clk_i);
    @(negedge clk_i);
    chk("mul result", res, exp);
  endtask

  task mac_t;
    @(posedge clk_i);
    an <= 0;
    bn <= 0;
    wbx(1, `DMB_ADR_CTRL, 32'h057);
    repeat (4) @(posedge clk_i);
    wbx(1, `DMB_ADR_CTRL, 32'h457);
    an <= 3;
    bn <= 4;
    @(posedge clk_i);
    an <= 18'h3fffe;
    bn <= 5;
    sgn <= 1;
    sub <= 1;
    @(posedge clk_i);
    sgn <= 0;
    sub <= 0;
    @(posedge clk_i);
    an <= 0;
    bn <= 0;
    repeat (6) @(posedge clk_i);
    @(negedge clk_i);
    chk("mac sum", res, 52'd1310732);
    chk("mac ovf", ovf, 0);
    wbx(0, `DMB_ADR_CTRL, 0);
    chk("ctrl clr", rd, 32'h057);
    ce <= 0;
    an <= 5;
    bn <= 5;
    repeat (6) @(posedge clk_i);
    @(negedge clk_i);
    chk("ce hold", res, 52'd1310732);
    @(posedge clk_i);
    ce <= 1;
    an <= 0;
    bn <= 0;
  endtask

  // Unsigned subtract below zero: overflow timing against result
  task ovf_t;
    wbx(1, `DMB_ADR_CTRL, 32'h487);
    an <= 1;
    bn <= 1;
    @(posedge clk_i);
    an <= 0;
    bn <= 0;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    chk("wrap early", res, 0);
    chk("ovf early", ovf, 0);
    @(negedge clk_i);
    chk("wrap", res, 52'hfffffffffffff);
    chk("ovf set", ovf, 1);
    @(negedge clk_i);
    chk("ovf drop", ovf, 0);
    wbx(0, `DMB_ADR_STAT, 0);
    chk("stat", rd, 32'h2);
  endtask

  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 0;
    wbx(0, `DMB_ADR_CTRL, 0);
    chk("ctrl rst", rd, `DMB_CTRL_RST);
    wbx(0, `DMB_ADR_CAP0, 0);
    chk("cap0", rd, {8'h22, 8'h42, 8'h21, 8'h48});
    wbx(0, `DMB_ADR_CAP1, 0);
    chk("cap1", rd, `DMB_CAP1_VAL);
    wbx(0, 8'h20, 0);
    chk("unmapped", rd, 0);
    multiply_only_element_t(32'h00e, 4, 63);
    multiply_only_element_t(32'h000, 1, 63);
    multiply_only_element_t(32'h004, 2, 63);
    multiply_only_element_t(32'h302, 2, 33);
    chk("chain a", asro, 11);
    chk("chain b", bsro, 3);
    mac_t;
    ovf_t;
    rst_i <= 1;
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    @(negedge clk_i);
    chk("rst res", res, 0);
    wbx(0, `DMB_ADR_CTRL, 0);
    chk("rst ctrl", rd, `DMB_CTRL_RST);
    summarize;
  end
endmodule
